// ==== verilog/ldcl_link.sv ====
// Diagnostic line and command logic of the two-channel LED driver
module ldcl_link (
    // System clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Supervisor levels from the analog side
    input  wire logic       enable_pin_i,
    input  wire logic       uvlo_i,
    input  wire logic       tsd_i,
    input  wire logic       over_temp_i,
    input  wire logic       power_good_i,
    input  wire logic       headroom_max_i,
    // Sink comparators
    input  wire logic       sink_a_under_i,
    input  wire logic       sink_b_under_i,
    input  wire logic       sink_a_over_i,
    input  wire logic       sink_b_over_i,
    // Dimming inputs, channel a is also the link clock
    input  wire logic       dim_clock_a,
    input  wire logic       dim_clock_b,
    // Open-drain diagnostic line
    input  wire logic       diag_line_i,
    output logic            diag_line_o,
    output logic            diag_line_oe_o,
    // Analog controls
    output logic            headroom_cap_gnd_o,
    output logic            sink_a_on_o,
    output logic            sink_b_on_o,
    output logic [1:0]      switching_rate_o,
    output logic            fault_present_o
);
    // Clears for the link domain, asserted from the pin levels directly
    logic link_clr;
    assign link_clr = rst_i | uvlo_i | tsd_i | !enable_pin_i;

    // Levels into the system clock domain
    logic [1:0] en_sync;
    logic [1:0] uv_sync;
    logic [1:0] tsd_sync;
    logic [1:0] ot_sync;
    logic [1:0] pg_sync;
    logic [1:0] da_sync;
    logic [1:0] db_sync;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            en_sync  <= ldcl_pkg::SYNC_RST;
            uv_sync  <= ldcl_pkg::SYNC_RST;
            tsd_sync <= ldcl_pkg::SYNC_RST;
            ot_sync  <= ldcl_pkg::SYNC_RST;
            pg_sync  <= ldcl_pkg::SYNC_RST;
            da_sync  <= ldcl_pkg::SYNC_RST;
            db_sync  <= ldcl_pkg::SYNC_RST;
        end else begin
            en_sync  <= {en_sync[0], enable_pin_i};
            uv_sync  <= {uv_sync[0], uvlo_i};
            tsd_sync <= {tsd_sync[0], tsd_i};
            ot_sync  <= {ot_sync[0], over_temp_i};
            pg_sync  <= {pg_sync[0], power_good_i};
            da_sync  <= {da_sync[0], dim_clock_a};
            db_sync  <= {db_sync[0], dim_clock_b};
        end
    end

    // Persistence counters per channel and per fault kind
    logic cond_uv_a;
    logic cond_uv_b;
    logic cond_ov_a;
    logic cond_ov_b;
    logic flg_uv_a;
    logic flg_uv_b;
    logic flg_ov_a;
    logic flg_ov_b;
    assign cond_uv_a = sink_a_under_i & headroom_max_i;
    assign cond_uv_b = sink_b_under_i & headroom_max_i;
    assign cond_ov_a = sink_a_over_i;
    assign cond_ov_b = sink_b_over_i;

    // Cleared by enable low, so a short enable pulse restarts the count
    logic fault_clr;
    assign fault_clr = link_clr | over_temp_i;

    ldcl_persist #(.COUNT(ldcl_pkg::PERSIST_PULSES), .W(ldcl_pkg::PERSIST_W)) u_uv_a (
        .dim_clk_i (dim_clock_a),
        .clr_i     (fault_clr),
        .cond_i    (cond_uv_a),
        .flag_o    (flg_uv_a)
    );
    ldcl_persist #(.COUNT(ldcl_pkg::PERSIST_PULSES), .W(ldcl_pkg::PERSIST_W)) u_uv_b (
        .dim_clk_i (dim_clock_b),
        .clr_i     (fault_clr),
        .cond_i    (cond_uv_b),
        .flag_o    (flg_uv_b)
    );
    ldcl_persist #(.COUNT(ldcl_pkg::PERSIST_PULSES), .W(ldcl_pkg::PERSIST_W)) u_ov_a (
        .dim_clk_i (dim_clock_a),
        .clr_i     (fault_clr),
        .cond_i    (cond_ov_a),
        .flag_o    (flg_ov_a)
    );
    ldcl_persist #(.COUNT(ldcl_pkg::PERSIST_PULSES), .W(ldcl_pkg::PERSIST_W)) u_ov_b (
        .dim_clk_i (dim_clock_b),
        .clr_i     (fault_clr),
        .cond_i    (cond_ov_b),
        .flag_o    (flg_ov_b)
    );

    // Channel-b flags cross into the channel-a domain
    logic [1:0] uvb_sync;
    logic [1:0] ovb_sync;
    always_ff @(negedge dim_clock_a or posedge fault_clr) begin
        if (fault_clr) begin
            uvb_sync <= ldcl_pkg::SYNC_RST;
            ovb_sync <= ldcl_pkg::SYNC_RST;
        end else begin
            uvb_sync <= {uvb_sync[0], flg_uv_b};
            ovb_sync <= {ovb_sync[0], flg_ov_b};
        end
    end

    // Pattern choice: overvoltage before undervoltage, channel a before b
    logic       pat_any;
    logic [3:0] pat_sel;
    always_comb begin
        pat_any = 1'b1;
        if (flg_ov_a) begin
            pat_sel = ldcl_pkg::PAT_OV_A;
        end else if (ovb_sync[1]) begin
            pat_sel = ldcl_pkg::PAT_OV_B;
        end else if (flg_uv_a) begin
            pat_sel = ldcl_pkg::PAT_UV_A;
        end else if (uvb_sync[1]) begin
            pat_sel = ldcl_pkg::PAT_UV_B;
        end else begin
            pat_sel = 4'h0;
            pat_any = 1'b0;
        end
    end

    // Link-domain serial engine, stepped on channel-a falling edges
    typedef enum logic [2:0] {
        LDCL_IDLE = 3'b001,
        LDCL_SEND = 3'b010,
        LDCL_RECV = 3'b100
    } ldcl_state_t;

    ldcl_state_t  st, next_st;
    logic [3:0]   tx_sh, next_tx_sh;
    logic [1:0]   tx_cnt, next_tx_cnt;
    logic [15:0]  rx_sh, next_rx_sh;
    logic         tx_bit, next_tx_bit;
    logic [1:0]   rate, next_rate;
    logic         cha_off, next_cha_off;
    logic         cmd_ok;

    // Power-good and warning seen by the link side
    // Separate copies: link edges and system edges never share a flop
    logic [1:0] pg_l;
    logic [1:0] ot_l;
    always_ff @(negedge dim_clock_a or posedge link_clr) begin
        if (link_clr) begin
            pg_l <= ldcl_pkg::SYNC_RST;
            ot_l <= ldcl_pkg::SYNC_RST;
        end else begin
            pg_l <= {pg_l[0], power_good_i};
            ot_l <= {ot_l[0], over_temp_i};
        end
    end

    assign cmd_ok = pg_l[1] & !ot_l[1] & !pat_any;

    always_comb begin
        next_st      = st;
        next_tx_sh   = tx_sh;
        next_tx_cnt  = tx_cnt;
        next_rx_sh   = {rx_sh[14:0], diag_line_i};
        next_tx_bit  = 1'b1;
        next_rate    = rate;
        next_cha_off = cha_off;
        case (st)
            LDCL_IDLE: begin
                if (pat_any) begin
                    next_st     = LDCL_SEND;
                    next_tx_sh  = {pat_sel[2:0], 1'b0};
                    next_tx_bit = pat_sel[3];
                    next_tx_cnt = 2'd1;
                end else begin
                    next_st = LDCL_RECV;
                end
            end
            LDCL_SEND: begin
                // Pattern repeats for as long as the fault stands
                if (!pat_any) begin
                    next_st = LDCL_IDLE;
                end else if (tx_cnt == 2'd0) begin
                    next_tx_sh  = {pat_sel[2:0], 1'b0};
                    next_tx_bit = pat_sel[3];
                    next_tx_cnt = 2'd1;
                end else begin
                    next_tx_bit = tx_sh[3];
                    next_tx_sh  = {tx_sh[2:0], 1'b0};
                    next_tx_cnt = tx_cnt + 2'd1;
                end
            end
            LDCL_RECV: begin
                if (pat_any) begin
                    next_st = LDCL_IDLE;
                end else if (cmd_ok) begin
                    case (next_rx_sh)
                        ldcl_pkg::CMD_RATE_NORM: next_rate = ldcl_pkg::RATE_NORMAL;
                        ldcl_pkg::CMD_RATE_M20:  next_rate = ldcl_pkg::RATE_DOWN20;
                        ldcl_pkg::CMD_RATE_M40:  next_rate = ldcl_pkg::RATE_DOWN40;
                        ldcl_pkg::CMD_CHA_OFF:   next_cha_off = 1'b1;
                        default: begin
                        end
                    endcase
                end
            end
            default: next_st = LDCL_IDLE;
        endcase
    end

    // Only falling edges of channel a and link_clr move state; an idle clock with link_clr low moves nothing
    always_ff @(negedge dim_clock_a or posedge link_clr) begin
        if (link_clr) begin
            st      <= LDCL_IDLE;
            tx_sh   <= '0;
            tx_cnt  <= '0;
            rx_sh   <= '0;
            tx_bit  <= 1'b1;
            rate    <= ldcl_pkg::RATE_NORMAL;
            cha_off <= 1'b0;
        end else begin
            st      <= next_st;
            tx_sh   <= next_tx_sh;
            tx_cnt  <= next_tx_cnt;
            rx_sh   <= next_rx_sh;
            tx_bit  <= next_tx_bit;
            rate    <= next_rate;
            cha_off <= next_cha_off;
        end
    end

    // Link state into the system domain, two flops each
    // tx_bit is high outside SEND, so the flop alone crosses, free of glitches
    logic [1:0] txb_sync;
    logic [1:0] off_sync;
    logic [1:0] pat_sync;
    logic [1:0] rate_s0;
    logic [1:0] rate_s1;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            txb_sync <= 2'h3;
            off_sync <= ldcl_pkg::SYNC_RST;
            pat_sync <= ldcl_pkg::SYNC_RST;
            rate_s0  <= ldcl_pkg::RATE_NORMAL;
            rate_s1  <= ldcl_pkg::RATE_NORMAL;
        end else begin
            txb_sync <= {txb_sync[0], tx_bit};
            off_sync <= {off_sync[0], cha_off};
            pat_sync <= {pat_sync[0], pat_any};
            rate_s0  <= rate;
            rate_s1  <= rate_s0;
        end
    end

    // Output flops in the system domain
    logic       next_drive_low;
    logic       next_gnd;
    logic       next_a_on;
    logic       next_b_on;
    logic [1:0] next_rate_o;
    logic       down;
    always_comb begin
        down           = uv_sync[1] | tsd_sync[1] | !en_sync[1];
        next_gnd       = down;
        // Warning wins, then power-good hold-off, then pattern bits
        next_drive_low = ot_sync[1] | !pg_sync[1] | !txb_sync[1];
        next_a_on      = da_sync[1] & !off_sync[1] & !down;
        next_b_on      = db_sync[1] & !down;
        // Two-bit word taken only once both stages agree, so skew never shows
        if (rate_s1 == rate_s0) begin
            next_rate_o = rate_s1;
        end else begin
            next_rate_o = switching_rate_o;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            diag_line_oe_o     <= 1'b1;
            headroom_cap_gnd_o <= 1'b1;
            sink_a_on_o        <= 1'b0;
            sink_b_on_o        <= 1'b0;
            switching_rate_o   <= ldcl_pkg::RATE_NORMAL;
            fault_present_o    <= 1'b0;
        end else begin
            diag_line_oe_o     <= next_drive_low;
            headroom_cap_gnd_o <= next_gnd;
            sink_a_on_o        <= next_a_on;
            sink_b_on_o        <= next_b_on;
            switching_rate_o   <= next_rate_o;
            fault_present_o    <= pat_sync[1];
        end
    end

    // Open drain: only ever drives low
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            diag_line_o <= 1'b0;
        end else begin
            diag_line_o <= 1'b0;
        end
    end
endmodule : ldcl_link

// ==== verilog/ldcl_pkg.sv ====
// Constants shared by the diagnostic and command link logic
package ldcl_pkg;
    // Persistence of a sink fault, in dimming pulses
    localparam int unsigned PERSIST_PULSES = 508;
    localparam int unsigned PERSIST_W      = 9;
    // Fault patterns, first bit sent is bit 3
    localparam logic [3:0] PAT_OV_A = 4'h1;
    localparam logic [3:0] PAT_OV_B = 4'h3;
    localparam logic [3:0] PAT_UV_A = 4'h5;
    localparam logic [3:0] PAT_UV_B = 4'h7;
    localparam int unsigned PAT_BITS = 4;
    // Sixteen-bit commands, first bit received is bit 15
    localparam int unsigned CMD_BITS      = 16;
    localparam logic [15:0] CMD_RATE_NORM = 16'hF777;
    localparam logic [15:0] CMD_RATE_M20  = 16'hF111;
    localparam logic [15:0] CMD_RATE_M40  = 16'hF333;
    localparam logic [15:0] CMD_CHA_OFF   = 16'hF555;
    // Switching rate setting encodings
    localparam logic [1:0] RATE_NORMAL = 2'h0;
    localparam logic [1:0] RATE_DOWN20 = 2'h1;
    localparam logic [1:0] RATE_DOWN40 = 2'h2;
    // Minimum dimming pulse width, for reference by the other party
    localparam int unsigned MIN_DIM_NS = 300;
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned MIN_DIM_CYC = (MIN_DIM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Reset value of the two-flop synchroniser stages, except txb_sync, which resets high
    localparam logic [1:0] SYNC_RST = 2'h0;
endpackage : ldcl_pkg

// ==== verilog/ldcl_persist.sv ====
// Per-channel fault persistence counter, clocked by that channel's dimming input
module ldcl_persist #(
    parameter int unsigned COUNT = 508,
    parameter int unsigned W     = 9
) (
    // Clock and clear
    input  wire logic dim_clk_i,
    input  wire logic clr_i,
    // Sampled sink condition
    input  wire logic cond_i,
    // Flag, held until clear
    output logic      flag_o
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_flag;

    always_comb begin
        next_cnt  = cnt;
        next_flag = flag_o;
        if (!cond_i) begin
            next_cnt = '0;
        end else if (cnt == W'(COUNT - 1)) begin
            next_flag = 1'b1;
        end else begin
            next_cnt = cnt + W'(1);
        end
    end

    // Condition sampled at the end of each high pulse
    always_ff @(negedge dim_clk_i or posedge clr_i) begin
        if (clr_i) begin
            cnt    <= '0;
            flag_o <= 1'b0;
        end else begin
            cnt    <= next_cnt;
            flag_o <= next_flag;
        end
    end
endmodule : ldcl_persist

// ==== testbench/ldcl_link_monitor.sv ====
// Port-level assertions for the diagnostic and command link
module ldcl_link_monitor (
    // Clock, reset and inputs
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       enable_pin_i,
    input wire logic       uvlo_i,
    input wire logic       tsd_i,
    input wire logic       over_temp_i,
    input wire logic       power_good_i,
    input wire logic       dim_clock_a,
    input wire logic       dim_clock_b,
    // Outputs under watch
    input wire logic       diag_line_oe_o,
    input wire logic       headroom_cap_gnd_o,
    input wire logic       sink_a_on_o,
    input wire logic       sink_b_on_o,
    input wire logic [1:0] switching_rate_o,
    input wire logic       fault_present_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Four samples cover the two-flop sync plus the output flop
    sequence s_down_held;
        (uvlo_i || tsd_i || !enable_pin_i)[*4];
    endsequence
    sequence s_warn_held;
        over_temp_i[*4];
    endsequence
    sequence s_link_quiet;
        (!dim_clock_a && power_good_i && !over_temp_i && enable_pin_i && !uvlo_i && !tsd_i)[*6];
    endsequence
    a_gnd_on_down: assert property ($rose(uvlo_i || tsd_i || !enable_pin_i) |-> ##[0:4] headroom_cap_gnd_o)
        else $error("Headroom node not grounded");
    a_line_no_pg: assert property (!power_good_i[*4] |-> diag_line_oe_o)
        else $error("Line released before power good");
    a_warn_line_low: assert property (s_warn_held |-> diag_line_oe_o)
        else $error("Line not low during warning");
    a_warn_clears: assert property (s_warn_held |-> !fault_present_o)
        else $error("Pattern kept during warning");
    a_down_clears: assert property (s_down_held |-> !fault_present_o && switching_rate_o == ldcl_pkg::RATE_NORMAL)
        else $error("Fault or rate kept while disabled");
    a_sink_b_on: assert property ((dim_clock_b && enable_pin_i && !uvlo_i && !tsd_i)[*4] |-> sink_b_on_o)
        else $error("Sink b off while dimming high");
    a_sink_idle: assert property ((!dim_clock_a && !dim_clock_b)[*4] |-> !sink_a_on_o && !sink_b_on_o)
        else $error("Sink on while dimming low");
    a_quiet_line: assert property (s_link_quiet |-> $stable(diag_line_oe_o))
        else $error("Line moved without link clock edge");
endmodule : ldcl_link_monitor

bind ldcl_link ldcl_link_monitor u_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .enable_pin_i(enable_pin_i), .uvlo_i(uvlo_i), .tsd_i(tsd_i),
    .over_temp_i(over_temp_i), .power_good_i(power_good_i), .dim_clock_a(dim_clock_a),
    .dim_clock_b(dim_clock_b), .diag_line_oe_o(diag_line_oe_o),
    .headroom_cap_gnd_o(headroom_cap_gnd_o), .sink_a_on_o(sink_a_on_o), .sink_b_on_o(sink_b_on_o),
    .switching_rate_o(switching_rate_o), .fault_present_o(fault_present_o)
);

// ==== testbench/ldcl_mcu_model.sv ====
// Controller model: dimming clocks and the pulled-up open-drain line
module ldcl_mcu_model (
    // Device pull-down request
    input  wire logic diag_line_oe_i,
    // To the device
    output logic      dim_clock_a,
    output logic      dim_clock_b,
    output logic      diag_line
);
    timeunit 1ns;
    timeprecision 100ps;
    logic pull_low;
    initial begin
        dim_clock_a = 1'b0;
        dim_clock_b = 1'b0;
        pull_low    = 1'b0;
    end
    // Released line rises through the pull-up
    assign diag_line = (diag_line_oe_i || pull_low) ? 1'b0 : 1'b1;
    // One bit per pulse, both clocks together; idle low between calls
    task automatic clocks(input int n, input logic [15:0] tx, output logic [15:0] rx);
        logic [15:0] t;
        t  = tx;
        rx = 16'h0000;
        for (int i = 0; i < n; i++) begin
            pull_low = !t[15];
            t = {t[14:0], 1'b1};
            #20ns;
            dim_clock_a = 1'b1;
            dim_clock_b = 1'b1;
            // Late sample leaves room for a slow rise
            #36ns;
            rx = {rx[14:0], diag_line};
            dim_clock_a = 1'b0;
            dim_clock_b = 1'b0;
            #24ns;
        end
        pull_low = 1'b0;
    endtask : clocks
endmodule : ldcl_mcu_model

// ==== testbench/test_led_driver_diag_command_link.sv ====
// Self-checking bench for the diagnostic and command link
module test_led_driver_diag_command_link;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        enable_pin_i = 1'b1;
    logic        uvlo_i = 1'b0;
    logic        tsd_i = 1'b0;
    logic        over_temp_i = 1'b0;
    logic        power_good_i = 1'b0;
    logic        headroom_max_i = 1'b1;
    logic [3:0]  cond = 4'h0;
    logic        dim_a, dim_b, line, line_oe, gnd, sink_a, sink_b, fault;
    logic        line_drv;
    logic [1:0]  rate;
    logic [15:0] rx;
    logic [3:0]  pats [4] = '{ldcl_pkg::PAT_OV_A, ldcl_pkg::PAT_OV_B,
                              ldcl_pkg::PAT_UV_A, ldcl_pkg::PAT_UV_B};
    int          err_total = 0;
    int          n_compared = 0;
    ldcl_link uut (
        .clk_i(clk_i), .rst_i(rst_i), .enable_pin_i(enable_pin_i), .uvlo_i(uvlo_i), .tsd_i(tsd_i),
        .over_temp_i(over_temp_i), .power_good_i(power_good_i), .headroom_max_i(headroom_max_i),
        .sink_a_over_i(cond[3]), .sink_b_over_i(cond[2]), .sink_a_under_i(cond[1]),
        .sink_b_under_i(cond[0]), .dim_clock_a(dim_a), .dim_clock_b(dim_b), .diag_line_i(line),
        .diag_line_o(line_drv), .diag_line_oe_o(line_oe), .headroom_cap_gnd_o(gnd),
        .sink_a_on_o(sink_a),
        .sink_b_on_o(sink_b), .switching_rate_o(rate), .fault_present_o(fault)
    );
    ldcl_mcu_model mcu (
        .diag_line_oe_i(line_oe), .dim_clock_a(dim_a), .dim_clock_b(dim_b), .diag_line(line)
    );
    always #2ns clk_i = ~clk_i;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic en_pulse();
        cyc(1);
        enable_pin_i = 1'b0;
        cyc(49);
        check(16'(gnd), 16'h0001);
        enable_pin_i = 1'b1;
        cyc(8);
    endtask : en_pulse
    task automatic sink_check(input logic exp_a);
        fork
            mcu.clocks(1, 16'hFFFF, rx);
            begin
                @(posedge dim_a);
                cyc(6);
                check({14'h0, sink_a, sink_b}, {14'h0, exp_a, 1'b1});
            end
        join
    endtask : sink_check
    task automatic t_power_up();
        check({14'h0, rate}, 16'(ldcl_pkg::RATE_NORMAL));
        for (int i = 0; i < 3; i++) begin
            {uvlo_i, tsd_i, enable_pin_i} = {i == 0, i == 1, i != 2};
            cyc(5);
            check(16'(gnd), 16'h0001);
        end
        enable_pin_i = 1'b1;
        tsd_i = 1'b0;
        cyc(5);
        check({14'h0, gnd, line_oe}, 16'h0001);
        power_good_i = 1'b1;
        cyc(5);
        check(16'(line_oe), 16'h0000);
        check(16'(line_drv), 16'h0000);
        sink_check(1'b1);
    endtask : t_power_up
    task automatic t_commands();
        logic [15:0] cmd [4] = '{ldcl_pkg::CMD_RATE_M20, ldcl_pkg::CMD_RATE_M40,
                                ldcl_pkg::CMD_RATE_NORM, ldcl_pkg::CMD_RATE_M40};
        logic [1:0]  exp [4] = '{ldcl_pkg::RATE_DOWN20, ldcl_pkg::RATE_DOWN40,
                                ldcl_pkg::RATE_NORMAL, ldcl_pkg::RATE_DOWN40};
        mcu.clocks(4, 16'hFFFF, rx);
        for (int i = 0; i < 4; i++) begin
            mcu.clocks(16, cmd[i], rx);
            cyc(6);
            check({14'h0, rate}, {14'h0, exp[i]});
        end
        mcu.clocks(16, ldcl_pkg::CMD_CHA_OFF, rx);
        sink_check(1'b0);
        en_pulse();
        check({14'h0, rate}, 16'(ldcl_pkg::RATE_NORMAL));
        sink_check(1'b1);
    endtask : t_commands
    task automatic t_fault(input int i, input logic [3:0] pat);
        logic [7:0] dup;
        logic       hit;
        dup = {pat, pat};
        hit = 1'b0;
        en_pulse();
        cond = 4'h8 >> i;
        // Two short of the persistence count
        mcu.clocks(506, 16'hFFFF, rx);
        cyc(8);
        check(16'(fault), 16'h0000);
        mcu.clocks(24, 16'hFFFF, rx);
        cyc(8);
        check(16'(fault), 16'h0001);
        for (int k = 0; k < 4; k++) hit |= (rx === {4{dup[7-k -: 4]}});
        check(16'(hit), 16'h0001);
        mcu.clocks(16, ldcl_pkg::CMD_RATE_M40, rx);
        cyc(6);
        check({14'h0, rate}, 16'(ldcl_pkg::RATE_NORMAL));
        over_temp_i = 1'b1;
        cyc(6);
        check({14'h0, fault, line_oe}, 16'h0001);
        over_temp_i = 1'b0;
        cond = 4'h0;
        en_pulse();
        check(16'(fault), 16'h0000);
    endtask : t_fault
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        cyc(16);
        rst_i = 1'b0;
        cyc(4);
        t_power_up();
        t_commands();
        for (int i = 0; i < 4; i++) t_fault(i, pats[i]);
        print_verdict();
    end
    // About 2300 link pulses of 80 ns expected, with margin
    initial begin
        #300us;
        err_total++;
        print_verdict();
    end
endmodule : test_led_driver_diag_command_link
